/* File: timer_pkg.sv */
// package: register map, control word fields and reset values
package timer_pkg;
  localparam int          DATA_W        = 8;
  localparam int          CNT_W         = 16;
  localparam int          NUM_CH        = 3;
  localparam logic [1:0]  PORT_CNT0     = 2'h0;
  localparam logic [1:0]  PORT_CNT1     = 2'h1;
  localparam logic [1:0]  PORT_CNT2     = 2'h2;
  localparam logic [1:0]  PORT_SETUP    = 2'h3;
  localparam int          SEL_HI        = 7;
  localparam int          SEL_LO        = 6;
  localparam int          ACC_HI        = 5;
  localparam int          ACC_LO        = 4;
  localparam int          STYLE_HI      = 3;
  localparam int          STYLE_LO      = 1;
  localparam int          FMT_BIT       = 0;
  localparam logic [1:0]  ACC_LATCH     = 2'h0;
  localparam logic [1:0]  ACC_LOW_ONLY  = 2'h1;
  localparam logic [1:0]  ACC_HIGH_ONLY = 2'h2;
  localparam logic [1:0]  ACC_LOW_HIGH  = 2'h3;
  localparam logic [2:0]  STYLE_TC_INT  = 3'h0;
  localparam logic [5:0]  SETUP_RST     = 6'h30;
  localparam logic [15:0] CNT_RST       = 16'h0000;
  localparam logic [7:0]  RD_IDLE       = 8'hff;
endpackage

/* File: count_channel.sv */
// one 16-bit down counter with load sequencing, latch and read sequencing
`timescale 1ns/1ps
module count_channel
  import timer_pkg::*;
#(
  parameter int W = timer_pkg::CNT_W
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  input  wire logic         setup_we,
  input  wire logic [5:0]   setup_in,
  input  wire logic         latch_cmd,
  input  wire logic         data_we,
  input  wire logic         data_re,
  input  wire logic [7:0]   wdata,
  input  wire logic         cnt_clk,
  input  wire logic         gate,
  output logic [7:0]        rbyte,
  output logic [5:0]        setup_out,
  output logic [W-1:0]      count_out
);
  import timer_pkg::*;

  // byte splitting and the decimal decrement assume four digits of 4 bits
  if (W != 16) begin : g_bad_width
    $error("count_channel supports 16-bit counters only");
  end

  // ************************************************************
  // configuration and load sequencing
  // ************************************************************
  logic [5:0]   setup_r;
  logic [W-1:0] count_r;
  logic [W-1:0] pend_r;
  logic [W-1:0] hold_r;
  logic         hold_v_r;
  logic         wr_hi_r;
  logic         rd_hi_r;
  logic         armed_r;
  logic         halt_r;
  logic         clk_d_r;
  logic         rose_r;
  logic [1:0]   acc;

  assign acc       = setup_r[5:4];
  assign setup_out = setup_r;
  assign count_out = count_r;

  function automatic logic [W-1:0] dec_one(input logic [W-1:0] v,
                                           input logic bcd);
    logic [W-1:0] r;
    r = v;
    if (!bcd) begin
      r = v - 16'h0001;
    end else begin
      for (int d = 0; d < 4; d++) begin
        if (r[d*4 +: 4] != 4'h0) begin
          r[d*4 +: 4] = r[d*4 +: 4] - 4'h1;
          break;
        end
        r[d*4 +: 4] = 4'h9; // 0000 wraps to 9999: maximum count
      end
    end
    return r;
  endfunction

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      setup_r <= SETUP_RST;
      wr_hi_r <= 1'b0;
      pend_r  <= CNT_RST;
      armed_r <= 1'b0;
      halt_r  <= 1'b0;
    end else if (setup_we) begin
      setup_r <= setup_in;
      wr_hi_r <= 1'b0;
      armed_r <= 1'b0;
      halt_r  <= 1'b0;
    end else if (data_we) begin
      unique case (acc)
        ACC_LOW_ONLY: begin
          pend_r  <= {8'h00, wdata};
          armed_r <= 1'b1;
        end
        ACC_HIGH_ONLY: begin
          pend_r  <= {wdata, 8'h00};
          armed_r <= 1'b1;
        end
        ACC_LOW_HIGH: begin
          if (!wr_hi_r) begin
            pend_r[7:0] <= wdata;
            // a half-written pair must never reach the counter
            armed_r     <= 1'b0;
            // first byte stops terminal-count mode counting
            halt_r      <= (setup_r[3:1] == STYLE_TC_INT);
          end else begin
            pend_r[15:8] <= wdata;
            armed_r      <= 1'b1;
            halt_r       <= 1'b0;
          end
          wr_hi_r <= !wr_hi_r;
        end
        default: ;
      endcase
    end else if (armed_r && !cnt_clk && clk_d_r && rose_r) begin
      armed_r <= 1'b0;
    end
  end

  sequence tc_first_byte_s;
    data_we && !setup_we && acc == ACC_LOW_HIGH && !wr_hi_r
      && setup_r[3:1] == STYLE_TC_INT;
  endsequence
  tc_halt_a: assert property (@(posedge clk_sys)
    disable iff (!rst_b)
    tc_first_byte_s |=> halt_r)
    else $error("first byte did not stop terminal-count counting");

  // ************************************************************
  // counting on the channel clock, sampled on clk_sys
  // ************************************************************
  logic clk_fall;
  assign clk_fall = clk_d_r && !cnt_clk;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      clk_d_r <= 1'b0;
      rose_r  <= 1'b0;
    end else begin
      clk_d_r <= cnt_clk;
      if (data_we && acc != ACC_LATCH) begin
        rose_r <= 1'b0;
      end else if (cnt_clk && !clk_d_r) begin
        rose_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      count_r <= CNT_RST;
    end else if (clk_fall) begin
      if (armed_r && rose_r) begin
        count_r <= pend_r; // load after rise then fall
      end else if (gate && !halt_r) begin
        count_r <= dec_one(count_r, setup_r[FMT_BIT]);
      end
    end
  end

  sequence zero_step_s;
    clk_fall && !(armed_r && rose_r) && gate && !halt_r
      && count_r == '0;
  endsequence
  zero_bin_a: assert property (@(posedge clk_sys)
    disable iff (!rst_b)
    zero_step_s ##0 !setup_r[FMT_BIT] |=> count_r == 16'hffff)
    else $error("binary zero count did not wrap to maximum");
  zero_bcd_a: assert property (@(posedge clk_sys)
    disable iff (!rst_b)
    zero_step_s ##0 setup_r[FMT_BIT] |=> count_r == 16'h9999)
    else $error("decimal zero count did not wrap to maximum");

  // ************************************************************
  // latch and read sequencing
  // ************************************************************
  logic [W-1:0] src;
  assign src = hold_v_r ? hold_r : count_r;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      hold_r   <= CNT_RST;
      hold_v_r <= 1'b0;
      rd_hi_r  <= 1'b0;
      rbyte    <= RD_IDLE;
    end else if (setup_we) begin
      hold_v_r <= 1'b0;
      rd_hi_r  <= 1'b0;
    end else if (latch_cmd) begin
      if (!hold_v_r) begin
        hold_r   <= count_r;
        hold_v_r <= 1'b1;
      end
    end else if (data_re) begin
      unique case (acc)
        ACC_HIGH_ONLY: begin
          rbyte    <= src[15:8];
          hold_v_r <= 1'b0;
        end
        ACC_LOW_HIGH: begin
          rbyte    <= rd_hi_r ? src[15:8] : src[7:0];
          rd_hi_r  <= !rd_hi_r;
          if (rd_hi_r) hold_v_r <= 1'b0;
        end
        default: begin
          rbyte    <= src[7:0];
          hold_v_r <= 1'b0;
        end
      endcase
    end
  end

  held_stable_a: assert property (@(posedge clk_sys)
    disable iff (!rst_b)
    hold_v_r && !latch_cmd && !data_re && !setup_we
      |=> $stable(hold_r))
    else $error("held snapshot changed while held");
endmodule // count_channel

/* File: interval_timer_host_access.sv */
// top: bus decode for three down counters and the setup word location
`timescale 1ns/1ps
// Behaviour
// - setup words accepted for counters any order
// - count bytes may come any later time
// - counters decrement; zero means maximum count
// - terminal-count mode restarts only after full load
// - select 00/01/10 read counters; 11 illegal
// - two-byte read: low byte then high
// - access field 00 latches selected count
// - reads return snapshot; live counting continues
// - latch leaves mode, access, format unchanged
// - setup layout: select, access, style, format
// - access codes: latch, low, high, low-high
// - format bit: binary or four-digit decimal
// - load takes effect after clock rise, fall
module interval_timer_host_access
  import timer_pkg::*;
(
  input  wire logic                     clk_sys,
  input  wire logic                     rst_b,
  input  wire logic                     chip_sel_b,
  input  wire logic                     rd_b,
  input  wire logic                     wr_b,
  input  wire logic                     port_select_low,
  input  wire logic                     port_select_high,
  input  wire logic [timer_pkg::DATA_W-1:0] data_in,
  output logic [timer_pkg::DATA_W-1:0]  data_out,
  output logic                          data_oe,
  input  wire logic [timer_pkg::NUM_CH-1:0] cnt_clk,
  input  wire logic [timer_pkg::NUM_CH-1:0] gate
);
  import timer_pkg::*;

  // ************************************************************
  // strobe edge detection and decode
  // ************************************************************
  logic       rd_d_r;
  logic       wr_d_r;
  logic       rd_go;
  logic       wr_go;
  logic [1:0] port;
  logic [1:0] pick;

  assign port  = {port_select_high, port_select_low};
  assign rd_go = !chip_sel_b && !rd_b && rd_d_r;
  assign wr_go = !chip_sel_b && !wr_b && wr_d_r;
  assign pick  = {data_in[SEL_HI], data_in[SEL_LO]};

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rd_d_r <= 1'b1;
      wr_d_r <= 1'b1;
    end else begin
      rd_d_r <= rd_b || chip_sel_b;
      wr_d_r <= wr_b || chip_sel_b;
    end
  end

  logic [NUM_CH-1:0] setup_we;
  logic [NUM_CH-1:0] latch_cmd;
  logic [NUM_CH-1:0] data_we;
  logic [NUM_CH-1:0] data_re;
  logic [7:0]        rbyte [NUM_CH];
  logic [5:0]        setup_out [NUM_CH];
  logic              setup_go;
  logic              is_latch;

  assign setup_go = wr_go && port == PORT_SETUP && pick != 2'h3;
  assign is_latch = data_in[ACC_HI:ACC_LO] == ACC_LATCH;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      // any counter, any order, by its select field
      assign setup_we[g]  = setup_go && !is_latch && pick == 2'(g);
      assign latch_cmd[g] = setup_go && is_latch && pick == 2'(g);
      assign data_we[g]   = wr_go && port == 2'(g);
      assign data_re[g]   = rd_go && port == 2'(g);
      count_channel #(
        .W (CNT_W)
      ) u_ch (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .setup_we  (setup_we[g]),
        .setup_in  (data_in[5:0]),
        .latch_cmd (latch_cmd[g]),
        .data_we   (data_we[g]),
        .data_re   (data_re[g]),
        .wdata     (data_in),
        .cnt_clk   (cnt_clk[g]),
        .gate      (gate[g]),
        .rbyte     (rbyte[g]),
        .setup_out (setup_out[g]),
        .count_out ()
      );
      latch_keeps_a: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        latch_cmd[g] |=> $stable(setup_out[g]))
        else $error("latch command altered channel setup");
    end
  endgenerate

  // ************************************************************
  // read data return
  // ************************************************************
  logic [1:0] rport_r;
  logic       rd_act_r;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rport_r  <= PORT_SETUP;
      rd_act_r <= 1'b0;
    end else begin
      if (rd_go) rport_r <= port;
      rd_act_r <= !chip_sel_b && !rd_b;
    end
  end

  // setup location and illegal code never drive data
  always_comb begin
    data_out = RD_IDLE;
    unique case (rport_r)
      PORT_CNT0:  data_out = rbyte[0];
      PORT_CNT1:  data_out = rbyte[1];
      PORT_CNT2:  data_out = rbyte[2];
      PORT_SETUP: data_out = RD_IDLE;
    endcase
  end
  assign data_oe = rd_act_r && !chip_sel_b && !rd_b
                   && rport_r != PORT_SETUP;

  no_cs_no_drive_a: assert property (@(posedge clk_sys)
    disable iff (!rst_b)
    chip_sel_b |-> !data_oe)
    else $error("data driven without chip select");
  no_setup_read_a: assert property (@(posedge clk_sys)
    disable iff (!rst_b)
    rd_go && port == PORT_SETUP |=> !data_oe)
    else $error("setup location was readable");
endmodule // interval_timer_host_access

/* File: host_model.sv */
// host bus model: issues port reads and writes to the timer block
`timescale 1ns/1ps
module host_model
  import timer_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  output logic            chip_sel_b,
  output logic            rd_b,
  output logic            wr_b,
  output logic            port_select_low,
  output logic            port_select_high,
  output logic [7:0]      data_in
);
  // ********
  // bus cycles
  // ********
  initial begin
    {chip_sel_b, rd_b, wr_b} = 3'h7;
    {port_select_high, port_select_low} = 2'h0;
    data_in = 8'h00;
  end
  // one strobe per call; the next call's first wait gives the high cycle
  task automatic wr(input logic [1:0] p, input logic [7:0] d,
                    input logic cs = 1'b0);
    @(negedge clk_sys);
    {chip_sel_b, wr_b} = {cs, 1'b0};
    {port_select_high, port_select_low} = p;
    data_in = d;
    @(negedge clk_sys);
    {chip_sel_b, wr_b} = 2'h3;
    // released bus must not keep showing the last byte
    data_in = ~d;
  endtask
  task automatic rd(input logic [1:0] p, output logic [7:0] q,
                    output logic oe, input logic cs = 1'b0);
    @(negedge clk_sys);
    {chip_sel_b, rd_b} = {cs, 1'b0};
    {port_select_high, port_select_low} = p;
    repeat (2) @(negedge clk_sys);
    q = data_out;
    oe = data_oe;
    {chip_sel_b, rd_b} = 2'h3;
  endtask
endmodule // host_model

/* File: testbench.sv */
// self-checking bench for the timer host access block
`timescale 1ns/1ps
module testbench;
  import timer_pkg::*;
  logic       clk_sys, rst_b, chip_sel_b, rd_b, wr_b;
  logic       port_select_low, port_select_high, data_oe;
  logic [7:0] data_in, data_out;
  logic [2:0] cnt_clk, gate;
  int         fails, tests_run;
  interval_timer_host_access i_dut (.clk_sys, .rst_b, .chip_sel_b, .rd_b,
    .wr_b, .port_select_low, .port_select_high, .data_in, .data_out,
    .data_oe, .cnt_clk, .gate);
  host_model i_host (.clk_sys, .data_out, .data_oe, .chip_sel_b, .rd_b,
    .wr_b, .port_select_low, .port_select_high, .data_in);
  // ********
  // helpers
  // ********
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  // count clock is sampled on clk_sys, so each phase lasts at least two cycles
  task automatic tick(input int c, input int n);
    repeat (n) begin
      @(negedge clk_sys);
      cnt_clk[c] = 1'b1;
      repeat (2) @(negedge clk_sys);
      cnt_clk[c] = 1'b0;
      repeat (2) @(negedge clk_sys);
    end
  endtask
  task automatic rdc(input logic [1:0] p, output logic [7:0] q);
    logic oe;
    i_host.rd(p, q, oe);
    chk(oe, 1'b1);
  endtask
  task automatic rd16(input logic [1:0] p, input logic [15:0] exp);
    logic [7:0] lo, hi;
    rdc(p, lo);
    rdc(p, hi);
    chk({hi, lo}, exp);
  endtask
  task automatic ld16(input logic [1:0] p, input logic [15:0] v);
    i_host.wr(p, v[7:0]);
    i_host.wr(p, v[15:8]);
  endtask
  task automatic end_sim;
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_reset;
    chk(data_out, RD_IDLE);
    chk(data_oe, 1'b0);
  endtask
  task automatic t_load;
    i_host.wr(PORT_SETUP, 8'h34);
    i_host.wr(PORT_CNT0, 8'h10);
    i_host.wr(PORT_SETUP, 8'h70);
    i_host.wr(PORT_CNT0, 8'h27);
    tick(0, 1);
    rd16(PORT_CNT0, 16'h2710);
  endtask
  task automatic t_count;
    gate[0] = 1'b1;
    tick(0, 3);
    gate[0] = 1'b0;
    rd16(PORT_CNT0, 16'h270d);
  endtask
  task automatic t_zero;
    for (int c = 1; c < 3; c++) begin
      i_host.wr(PORT_SETUP, {c[1:0], 2'h3, 3'h0, c[1]});
      ld16(c[1:0], 16'h0000);
      tick(c, 1);
      gate[c] = 1'b1;
      tick(c, 1);
      gate[c] = 1'b0;
      rd16(c[1:0], c == 1 ? 16'hffff : 16'h9999);
    end
  endtask
  task automatic t_latch;
    gate[0] = 1'b1;
    i_host.wr(PORT_SETUP, 8'h0f);
    tick(0, 2);
    gate[0] = 1'b0;
    rd16(PORT_CNT0, 16'h270d);
    rd16(PORT_CNT0, 16'h270b);
  endtask
  task automatic t_tc;
    // counter 0 into terminal-count mode, binary, low then high byte
    i_host.wr(PORT_SETUP, 8'h30);
    gate[0] = 1'b1;
    i_host.wr(PORT_CNT0, 8'h00);
    tick(0, 2);
    gate[0] = 1'b0;
    rd16(PORT_CNT0, 16'h270b);
    i_host.wr(PORT_CNT0, 8'h01);
    tick(0, 1);
    rd16(PORT_CNT0, 16'h0100);
  endtask
  task automatic t_byte;
    logic [7:0] q;
    i_host.wr(PORT_SETUP, 8'h50);
    i_host.wr(PORT_CNT1, 8'h5a);
    tick(1, 1);
    rdc(PORT_CNT1, q);
    chk(q, 8'h5a);
    i_host.wr(PORT_SETUP, 8'h60);
    i_host.wr(PORT_CNT1, 8'h12);
    tick(1, 1);
    rdc(PORT_CNT1, q);
    chk(q, 8'h12);
  endtask
  task automatic t_refuse;
    logic [7:0] q;
    logic       oe;
    i_host.wr(PORT_CNT1, 8'h77, 1'b1);
    tick(1, 1);
    rdc(PORT_CNT1, q);
    chk(q, 8'h12);
    i_host.rd(PORT_CNT0, q, oe, 1'b1);
    chk(oe, 1'b0);
    i_host.rd(PORT_SETUP, q, oe);
    chk(oe, 1'b0);
    chk(q, RD_IDLE);
  endtask
  // ********
  // run
  // ********
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    rst_b = 1'b0;
    cnt_clk = 3'h0;
    gate = 3'h0;
    fails = 0;
    tests_run = 0;
    repeat (8) @(negedge clk_sys);
    rst_b = 1'b1;
    @(negedge clk_sys);
    t_reset();
    t_load();
    t_count();
    t_zero();
    t_latch();
    t_tc();
    t_byte();
    t_refuse();
    end_sim();
  end
  // whole run needs well under a thousand cycles
  initial begin
    #500us;
    fails++;
    end_sim();
  end
endmodule // testbench
